// ==== inc/usb_ep_pkg.sv ====
package usb_ep_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_CSR2 = 4'h0;
    localparam logic [3:0] ADDR_EPCSR = 4'h4;
    localparam logic [3:0] ADDR_CRCON = 4'h8;
    localparam logic [3:0] ADDR_EPSEL = 4'hC;
    // Endpoint control bit positions
    localparam int B_AUTO = 31;
    localparam int B_ISO = 30;
    localparam int B_DIR = 29;
    localparam int B_DMAEN = 28;
    localparam int B_FRC = 27;
    localparam int B_DMAMD = 26;
    localparam int B_TWEN = 25;
    localparam int B_TGL = 24;
    localparam int B_TXRDY = 16;
    // Status 2 bit positions
    localparam int B_SOF = 19;
    localparam int B_RST = 18;
    localparam int B_RES = 17;
    localparam int B_SUSP = 16;
    // Clock/reset control positions
    localparam int B_GIF = 26;
    localparam int B_RWF = 25;
    localparam int B_ACT = 24;
    localparam int B_IE = 2;
    // Reset values and endpoint count
    localparam logic [7:1] RXIE_RST = 7'h00;
    localparam logic [10:0] MAXP_RST = 11'h040;
    localparam int NUM_EP = 7;
    // Bus events from the packet engine
    typedef struct packed {
        logic sof;
        logic babble;
        logic bus_reset;
        logic resume;
        logic suspend;
        logic activity;
    } bus_evt_s;
    // Per-endpoint control state
    typedef struct packed {
        logic auto_ready;
        logic iso;
        logic dir_tx;
        logic dma_en;
        logic dma_mode;
        logic toggle;
        logic pkt_ready;
        logic [10:0] max_size;
    } ep_ctl_s;
endpackage

// ==== src/usb_endpoint_tx_and_bus_events.sv ====
`timescale 1ns/1ps
module usb_endpoint_tx_and_bus_events
    import usb_ep_pkg::*;
#(
    parameter int DW = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Controller state
    input wire logic host_mode_i,
    input wire logic suspended_i,
    input wire bus_evt_s evt_i,
    // Packet engine per endpoint
    input wire logic [NUM_EP:1] pkt_sent_i,
    input wire logic [NUM_EP:1] ack_rx_i,
    input wire logic [NUM_EP:1] dma_need_i,
    input wire logic [NUM_EP:1] rx_irq_i,
    // Transmit data into FIFO (endpoint selected by index)
    input wire logic [DW-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_last_i,
    // FIFO side out
    output logic [DW-1:0] fifo_data_o,
    output logic fifo_valid_o,
    input wire logic fifo_ready_i,
    // Endpoint outputs
    output logic [NUM_EP:1] dma_req_o,
    output logic [NUM_EP:1] dma_mode_o,
    output logic [NUM_EP:1] ep_dir_tx_o,
    output logic [NUM_EP:1] ep_iso_o,
    output logic [NUM_EP:1] toggle_o,
    output logic [NUM_EP:1] pkt_ready_o,
    output logic [NUM_EP:1] flush_o,
    output logic [NUM_EP:1] rx_irq_o,
    output logic irq_req_o
);
    ////////////////////////////////////////////////////////////////
    // State
    ep_ctl_s ep_q [1:NUM_EP];        // Endpoint controls
    logic [NUM_EP:1] flush_q;        // Forced flush pulses
    logic [2:0] idx_q;               // Selected endpoint
    logic [10:0] load_cnt_q;         // Bytes loaded into FIFO
    logic [7:1] rxie_q;              // Receive interrupt enables
    logic sof_q, rst_q, res_q, susp_q; // Event flags
    logic gif_q, rwf_q, act_q;       // Clock/reset flags
    logic ie_q;                      // General interrupt enable
    logic ack_q;
    logic [31:0] rd_d;
    logic wr, wr_ep, wr_c2, wr_cr;
    logic [DW-1:0] b0_q, b1_q;       // Two-entry buffer
    logic [1:0] cnt_q;
    logic any_evt;
    logic full_pkt;

    // Bus write decode, taken on the acking edge
    assign wr = cyc_i && stb_i && we_i && !ack_q;
    assign wr_ep = wr && adr_i == ADDR_EPCSR;
    assign wr_c2 = wr && adr_i == ADDR_CSR2;
    assign wr_cr = wr && adr_i == ADDR_CRCON;
    assign ack_o = ack_q;

    ////////////////////////////////////////////////////////////////
    // Acknowledge one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    // Endpoint index register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_q <= 3'h1;
        end else if (wr && adr_i == ADDR_EPSEL && sel_i[0] && dat_i[2:0] != 3'h0) begin
            idx_q <= dat_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Two-entry FIFO buffer; stalls source when full
    assign tx_ready_o = cnt_q != 2'h2;
    assign fifo_valid_o = cnt_q != 2'h0;
    assign fifo_data_o = b0_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
            b0_q <= '0;
            b1_q <= '0;
        end else begin
            case ({tx_valid_i && tx_ready_o, fifo_valid_o && fifo_ready_i})
                2'b10: begin
                    if (cnt_q == 2'h0) b0_q <= tx_data_i;
                    else b1_q <= tx_data_i;
                    cnt_q <= cnt_q + 2'h1;
                end
                2'b01: begin
                    b0_q <= b1_q;
                    cnt_q <= cnt_q - 2'h1;
                end
                2'b11: begin
                    if (cnt_q == 2'h1) b0_q <= tx_data_i;
                    else begin
                        b0_q <= b1_q;
                        b1_q <= tx_data_i;
                    end
                end
                default: begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // Count loaded bytes toward maximum packet size
    assign full_pkt = tx_valid_i && tx_ready_o && (load_cnt_q + 11'h1 >= ep_q[idx_q].max_size);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_cnt_q <= 11'h0;
        end else if (tx_valid_i && tx_ready_o) begin
            load_cnt_q <= (full_pkt || tx_last_i) ? 11'h0 : load_cnt_q + 11'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Endpoint control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 1; i <= NUM_EP; i++) begin
                ep_q[i] <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, MAXP_RST};
            end
            flush_q <= '0;
        end else begin
            flush_q <= '0;
            for (int i = 1; i <= NUM_EP; i++) begin
                if (pkt_sent_i[i] || flush_q[i]) begin
                    ep_q[i].pkt_ready <= 1'b0;
                end
                if (pkt_sent_i[i] && ack_rx_i[i]) begin
                    ep_q[i].toggle <= !ep_q[i].toggle;
                end
                if (wr_ep && idx_q == 3'(i)) begin
                    if (sel_i[3]) begin
                        ep_q[i].auto_ready <= dat_i[B_AUTO];
                        ep_q[i].iso <= dat_i[B_ISO] && !host_mode_i;
                        ep_q[i].dir_tx <= dat_i[B_DIR];
                        ep_q[i].dma_en <= dat_i[B_DMAEN];
                        ep_q[i].dma_mode <= dat_i[B_DMAMD];
                        if (dat_i[B_FRC]) begin
                            ep_q[i].toggle <= !ep_q[i].toggle;
                            flush_q[i] <= 1'b1;
                        end else if (dat_i[B_TWEN]) begin
                            ep_q[i].toggle <= dat_i[B_TGL];
                        end
                    end
                    if (sel_i[2] && dat_i[B_TXRDY]) begin
                        ep_q[i].pkt_ready <= 1'b1;
                    end
                    if (sel_i[1]) ep_q[i].max_size[10:8] <= dat_i[10:8];
                    if (sel_i[0]) ep_q[i].max_size[7:0] <= dat_i[7:0];
                end
                if (idx_q == 3'(i) && full_pkt && ep_q[i].auto_ready) begin
                    ep_q[i].pkt_ready <= 1'b1;
                end
            end
        end
    end

    // Endpoint outputs
    always_comb begin
        for (int i = 1; i <= NUM_EP; i++) begin
            dma_req_o[i] = ep_q[i].dma_en && dma_need_i[i];
            dma_mode_o[i] = ep_q[i].dma_mode;
            ep_dir_tx_o[i] = ep_q[i].dir_tx;
            ep_iso_o[i] = ep_q[i].iso && !host_mode_i;
            toggle_o[i] = ep_q[i].toggle;
            pkt_ready_o[i] = ep_q[i].pkt_ready;
        end
    end
    assign flush_o = flush_q;
    assign rx_irq_o = rx_irq_i & rxie_q;

    ////////////////////////////////////////////////////////////////
    // Bus event flags; set wins over write-one clear
    assign any_evt = evt_i.sof || evt_i.babble || evt_i.bus_reset || evt_i.resume || evt_i.suspend;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sof_q <= 1'b0;
            rst_q <= 1'b0;
            res_q <= 1'b0;
            susp_q <= 1'b0;
            rxie_q <= RXIE_RST;
        end else begin
            if (wr_c2 && sel_i[2]) begin
                if (dat_i[B_SOF]) sof_q <= 1'b0;
                if (dat_i[B_RST]) rst_q <= 1'b0;
                if (dat_i[B_RES]) res_q <= 1'b0;
                if (dat_i[B_SUSP]) susp_q <= 1'b0;
            end
            if (wr_c2 && sel_i[0]) rxie_q <= dat_i[7:1];
            if (evt_i.sof) sof_q <= 1'b1;
            if (host_mode_i ? evt_i.babble : evt_i.bus_reset) rst_q <= 1'b1;
            if (evt_i.resume && suspended_i) res_q <= 1'b1;
            if (evt_i.suspend && !host_mode_i) susp_q <= 1'b1;
        end
    end

    // Clock/reset control flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gif_q <= 1'b0;
            rwf_q <= 1'b0;
            act_q <= 1'b1;
            ie_q <= 1'b0;
        end else begin
            if (wr_cr && sel_i[0]) ie_q <= dat_i[B_IE];
            if (wr_cr && sel_i[3]) begin
                if (dat_i[B_GIF]) gif_q <= 1'b0;
                if (dat_i[B_RWF]) rwf_q <= 1'b0;
                if (dat_i[B_ACT]) act_q <= 1'b0;
            end
            if (any_evt && ie_q) gif_q <= 1'b1;
            if (evt_i.resume && suspended_i) rwf_q <= 1'b1;
            if (evt_i.activity || any_evt) act_q <= 1'b1;
        end
    end
    assign irq_req_o = gif_q;

    ////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_d = 32'h0000_0000;
        case (adr_i)
            ADDR_CSR2: begin
                rd_d[B_SOF] = sof_q;
                rd_d[B_RST] = rst_q;
                rd_d[B_RES] = res_q;
                rd_d[B_SUSP] = susp_q;
                rd_d[7:1] = rxie_q;
            end
            ADDR_EPCSR: begin
                rd_d[B_AUTO] = ep_q[idx_q].auto_ready;
                rd_d[B_ISO] = ep_q[idx_q].iso && !host_mode_i;
                rd_d[B_DIR] = ep_q[idx_q].dir_tx;
                rd_d[B_DMAEN] = ep_q[idx_q].dma_en;
                rd_d[B_DMAMD] = ep_q[idx_q].dma_mode;
                rd_d[B_TGL] = ep_q[idx_q].toggle;
                rd_d[B_TXRDY] = ep_q[idx_q].pkt_ready;
                rd_d[10:0] = ep_q[idx_q].max_size;
            end
            ADDR_CRCON: begin
                rd_d[B_GIF] = gif_q;
                rd_d[B_RWF] = rwf_q;
                rd_d[B_ACT] = act_q;
                rd_d[B_IE] = ie_q;
            end
            ADDR_EPSEL: begin
                rd_d[2:0] = idx_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= rd_d;
        end
    end
endmodule

// ==== sim/usb_ep_props.sv ====
`timescale 1ns/1ps
module usb_ep_props
    import usb_ep_pkg::*;
#(
    parameter int DW = 8
) (
    // Clock, reset and bus handshake
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Controller state and endpoint pins
    input wire logic host_mode_i,
    input wire bus_evt_s evt_i,
    input wire logic [NUM_EP:1] dma_need_i,
    input wire logic [NUM_EP:1] rx_irq_i,
    input wire logic [NUM_EP:1] dma_req_o,
    input wire logic [NUM_EP:1] rx_irq_o,
    input wire logic [NUM_EP:1] ep_iso_o,
    input wire logic [NUM_EP:1] flush_o,
    input wire logic irq_req_o,
    // Buffer output side
    input wire logic [DW-1:0] fifo_data_o,
    input wire logic fifo_valid_o,
    input wire logic fifo_ready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Fresh request, then a single-cycle answer
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_one_cycle: assert property (s_req |=> s_ack) else $error("bus answer not one cycle");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("answer without request");
    a_dma_req_gated: assert property ((dma_req_o & ~dma_need_i) == '0) else $error("dma request without need");
    a_rx_irq_gated: assert property ((rx_irq_o & ~rx_irq_i) == '0) else $error("rx irq without source");
    a_iso_host_zero: assert property (host_mode_i |-> ep_iso_o == '0) else $error("iso active in host mode");
    a_gen_flag_cause: assert property ($rose(irq_req_o) |-> $past(evt_i != '0)) else $error("flag with no event");
    a_flush_one_pulse: assert property (flush_o != '0 |=> flush_o == '0) else $error("flush longer than one");
    a_buf_holds_word: assert property (fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_data_o))
        else $error("stalled word lost");
endmodule
bind usb_endpoint_tx_and_bus_events usb_ep_props #(.DW(DW)) u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
    .host_mode_i, .evt_i, .dma_need_i, .rx_irq_i, .dma_req_o, .rx_irq_o, .ep_iso_o, .flush_o, .irq_req_o,
    .fifo_data_o, .fifo_valid_o, .fifo_ready_i);

// ==== sim/fifo_sink_model.sv ====
`timescale 1ns/1ps
module fifo_sink_model #(
    parameter int DW = 8
) (
    // Clock and pacing
    input wire logic clk_i,
    input wire logic stall_i,
    // Words from the block
    input wire logic [DW-1:0] data_i,
    input wire logic valid_i,
    output logic ready_o = 1'b0,
    // Words taken, one pulse each
    output logic [DW-1:0] got_o,
    output logic got_v_o = 1'b0
);
    logic [1:0] pace_q = 2'h0; // Slow far side: takes one word in four cycles
    // Accept on ready, report what was taken
    always @(posedge clk_i) begin
        pace_q <= pace_q + 2'h1;
        ready_o <= !stall_i && (pace_q == 2'h0);
        got_v_o <= valid_i && ready_o;
        got_o <= data_i;
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import usb_ep_pkg::*;
    ////////////////////////////////////////////////////////////
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, host_mode_i, suspended_i, irq_req_o, stall, got_v;
    logic tx_valid_i, tx_ready_o, tx_last_i, fifo_valid_o, fifo_ready_i;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, rd, base;
    logic [7:0] tx_data_i, fifo_data_o, got;
    bus_evt_s evt_i;
    logic [NUM_EP:1] pkt_sent_i, ack_rx_i, dma_need_i, rx_irq_i, dma_req_o, dma_mode_o, ep_dir_tx_o, ep_iso_o;
    logic [NUM_EP:1] toggle_o, pkt_ready_o, flush_o, rx_irq_o, en;
    int num_errors, checks, seed, cyc_n, nflush;
    int exp_b[5] = '{B_SOF, B_RST, B_RST, B_RES, B_SUSP}; // Flag expected per event case
    logic [7:0] exp_q[$]; // Words expected at the far side
    usb_endpoint_tx_and_bus_events uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .host_mode_i, .suspended_i, .evt_i, .pkt_sent_i, .ack_rx_i, .dma_need_i, .rx_irq_i, .tx_data_i,
        .tx_valid_i, .tx_ready_o, .tx_last_i, .fifo_data_o, .fifo_valid_o, .fifo_ready_i, .dma_req_o,
        .dma_mode_o, .ep_dir_tx_o, .ep_iso_o, .toggle_o, .pkt_ready_o, .flush_o, .rx_irq_o, .irq_req_o);
    fifo_sink_model #(.DW(8)) sink (.clk_i, .stall_i(stall), .data_i(fifo_data_o), .valid_i(fifo_valid_o),
        .ready_o(fifo_ready_i), .got_o(got), .got_v_o(got_v));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] bt(input int b);
        return 32'h1 << b;
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Classic single bus cycle, held until the answer
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // One byte into the buffer
    task automatic push(input logic [7:0] b);
        @(posedge clk_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= b;
        exp_q.push_back(b);
        do @(posedge clk_i); while (tx_ready_o !== 1'b1);
        tx_valid_i <= 1'b0;
    endtask
    task automatic pulse(input bus_evt_s e);
        @(posedge clk_i);
        evt_i <= e;
        @(posedge clk_i);
        evt_i <= '0;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Hang guard, far side words and flush pulses
    always @(posedge clk_i) begin
        cyc_n++;
        if (flush_o[1] === 1'b1) nflush++;
        if (got_v === 1'b1) cmp("stream", exp_q.pop_front(), got);
        if (cyc_n == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        {seed, num_errors, checks, cyc_n, nflush} = {32'd78025, 128'd0};
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, host_mode_i, suspended_i, evt_i} = {1'b1, 51'h0};
        {pkt_sent_i, ack_rx_i, dma_need_i, rx_irq_i, tx_data_i, tx_valid_i, tx_last_i, stall} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, ADDR_CSR2, 0, 4'hF);
        cmp("status2", 32'h0, rd);
        wb(0, ADDR_CRCON, 0, 4'hF);
        cmp("crcon", bt(B_ACT), rd);
        wb(1, 4'h2, 32'hFFFFFFFF, 4'hF);
        wb(0, 4'h2, 0, 4'hF);
        cmp("unmapped", 32'h0, rd);
        wb(1, ADDR_EPSEL, 0, 4'hF);
        wb(0, ADDR_EPSEL, 0, 4'hF);
        cmp("index", 1, rd);
        base = bt(B_DIR) | bt(B_DMAEN) | bt(B_DMAMD) | 32'h4;
        wb(1, ADDR_EPCSR, base | bt(B_ISO), 4'hF);
        cmp("dir", 1, ep_dir_tx_o[1]);
        cmp("dma mode", 1, dma_mode_o[1]);
        cmp("iso", 1, ep_iso_o[1]);
        host_mode_i <= 1'b1;
        wb(0, ADDR_EPCSR, 0, 4'hF);
        cmp("iso host", 0, {rd[B_ISO], ep_iso_o[1]});
        host_mode_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            dma_need_i <= (i == 8) ? 7'h7F : 7'($random(seed));
            if (i == 8) base = base & ~bt(B_DMAEN);
            if (i == 8) wb(1, ADDR_EPCSR, base, 4'hF); // Mode stays set as enable drops
            @(posedge clk_i);
            cmp("dma req", (i == 8) ? 7'h00 : dma_need_i & 7'h01, dma_req_o);
        end
        wb(1, ADDR_EPCSR, base | bt(B_TGL), 4'hF);
        cmp("toggle locked", 0, toggle_o[1]);
        wb(1, ADDR_EPCSR, base | bt(B_TWEN) | bt(B_TGL), 4'hF);
        host_mode_i <= 1'b1;
        wb(0, ADDR_EPCSR, 0, 4'hF);
        cmp("toggle read", 1, rd[B_TGL]);
        host_mode_i <= 1'b0;
        wb(1, ADDR_EPCSR, base | bt(B_FRC), 4'hF);
        repeat (2) @(posedge clk_i);
        cmp("forced toggle", 0, toggle_o[1]);
        cmp("flush pulses", 1, nflush);
        en = 7'($random(seed));
        wb(1, ADDR_CSR2, {24'h0, en, 1'b1}, 4'h1);
        wb(0, ADDR_CSR2, 0, 4'hF);
        cmp("rx enables", {24'h0, en, 1'b0}, rd & 32'hFF);
        for (int i = 0; i < 4; i++) begin
            rx_irq_i <= 7'($random(seed));
            @(posedge clk_i);
            cmp("rx irq", rx_irq_i & en, rx_irq_o);
        end
        wb(1, ADDR_CRCON, bt(B_IE), 4'h1);
        wb(1, ADDR_CRCON, 32'h07000000, 4'h8);
        cmp("irq idle", 0, irq_req_o);
        for (int i = 0; i < 5; i++) begin
            host_mode_i <= (i == 1);
            suspended_i <= (i == 3);
            pulse(bus_evt_s'(6'h20 >> i));
            wb(0, ADDR_CSR2, 0, 4'hF);
            cmp("event flags", bt(exp_b[i]), rd & 32'h000F0000);
            wb(1, ADDR_CSR2, 32'h000F0000, 4'h4);
        end
        wb(0, ADDR_CRCON, 0, 4'hF);
        cmp("crcon flags", bt(B_GIF) | bt(B_RWF) | bt(B_IE), rd & 32'h06000004);
        cmp("irq req", 1, irq_req_o);
        wb(1, ADDR_CRCON, 32'h07000000, 4'h8);
        pulse(bus_evt_s'(6'h01));
        wb(0, ADDR_CRCON, 0, 4'hF);
        cmp("activity", bt(B_ACT), rd & bt(B_ACT));
        cmp("irq cleared", 0, irq_req_o);
        wb(1, ADDR_CRCON, 32'h07000000, 4'h9);
        pulse(bus_evt_s'(6'h20));
        wb(0, ADDR_CRCON, 0, 4'hF);
        cmp("gated flag", 0, {rd[B_GIF], irq_req_o});
        for (int a = 1; a >= 0; a--) begin
            wb(1, ADDR_EPCSR, base | (32'(a) << B_AUTO), 4'hF);
            stall <= 1'b1;
            repeat (2) push(8'($random(seed)));
            @(posedge clk_i);
            cmp("buffer full", 0, tx_ready_o);
            stall <= 1'b0;
            repeat (2) push(8'($random(seed)));
            while (exp_q.size() != 0) @(posedge clk_i);
            repeat (2) @(posedge clk_i);
            cmp("pkt ready", a, pkt_ready_o[1]);
            if (a == 0) wb(1, ADDR_EPCSR, base | bt(B_TXRDY), 4'hF); // Software sets ready by hand
            cmp("pkt ready set", 1, pkt_ready_o[1]);
            pkt_sent_i <= 7'h01;
            @(posedge clk_i);
            pkt_sent_i <= 7'h00;
            repeat (2) @(posedge clk_i);
            cmp("pkt ready clear", 0, pkt_ready_o[1]);
        end
        complete_run();
    end
endmodule
